/* File: design/tbf_defs.vh */
/*
 * Constants of the block framer: block fields, control byte codings,
 * information field sizes and length limits. Assumes nothing of its surroundings.
 */
// Notes on behaviour
// - prologue is node address, control byte, length byte, in that order
// - block is prologue, 0..254 information bytes, one check byte
// - node address bits 7 and 3 are sent as zero
// - terminal's first block sets the connection; same address pair keeps it
// - only source zero and destination zero addresses are accepted
// - info control byte: bit7 clear, sequence in bit6, more-data in bit5
// - receive-ready control byte: bits 7..5 are 100, expected sequence bit4
// - receive-ready low nibble: 0 ok, 1 checksum/parity, 2 other errors
// - supervisory control byte: bits 7,6 set; bit5 zero request, one response
// - supervisory low five bits: 0 resync, 1 size, 2 abort, 3 wait, 4 vpp
// - length byte counts information bytes, 0 up to 254
// - length 00 means no information field; length ff is never sent
// - info blocks carry application data; receive-ready blocks carry none
// - size and wait supervisory blocks carry one byte; others carry none
// - epilogue byte holds the check code of the block
// - every supervisory request gets the matching supervisory response
// - unchained info block is acknowledged by an info block
// - chained info block is acknowledged by receive-ready, other sequence
// - card may send wait request; terminal answers with wait response
// - size request is echoed by a size response; new size kept
// - both sizes default to 32; terminal size at most 254
// - after length bytes and check byte, receiver takes right to send
`ifndef TBF_DEFS_VH
`define TBF_DEFS_VH
`define TBF_NAD_DEFAULT 8'h00
`define TBF_NAD_UNUSED_MASK 8'h88
`define TBF_PCB_I_BIT 7
`define TBF_PCB_NS_BIT 6
`define TBF_PCB_M_BIT 5
`define TBF_PCB_NR_BIT 4
`define TBF_PCB_R_BASE 8'h80
`define TBF_PCB_S_BASE 8'hc0
`define TBF_PCB_S_RSP_BIT 5
`define TBF_R_OK 4'h0
`define TBF_R_EDC 4'h1
`define TBF_R_OTHER 4'h2
`define TBF_S_RESYNCH 5'h00
`define TBF_S_IFS 5'h01
`define TBF_S_ABORT 5'h02
`define TBF_S_WTX 5'h03
`define TBF_S_VPP 5'h04
`define TBF_LEN_MAX 8'hfe
`define TBF_LEN_RFU 8'hff
`define TBF_IFS_DEFAULT 8'h20
`define TBF_IFSD_MAX 8'hfe
`endif

/* File: design/tbf_buf2.v */
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
module tbf_buf2 #(
    parameter WIDTH = 9
) (
    input wire clk, // clock
    input wire rst, // async reset, active high
    input wire in_valid, // word offered
    output wire in_ready, // room for a word
    input wire [WIDTH-1:0] in_data, // word in
    output wire out_valid, // word available
    input wire out_ready, // consumer takes word
    output wire [WIDTH-1:0] out_data // word out, registered
);
    reg [WIDTH-1:0] mem0;
    reg [WIDTH-1:0] mem1;
    reg [1:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (count != 2'd2);
    assign out_valid = (count != 2'd0);
    assign out_data = mem0;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mem0 <= {WIDTH{1'b0}};
            mem1 <= {WIDTH{1'b0}};
            count <= 2'd0;
        end else begin
            // head sits in mem0 so the output always comes from a register
            if (pop) begin
                mem0 <= (push && count == 2'd1) ? in_data : mem1;
            end else if (push && count == 2'd0) begin
                mem0 <= in_data;
            end
            if (push && ((count == 2'd1 && !pop) || count == 2'd2)) begin
                mem1 <= in_data;
            end
            if (push && !pop) begin
                count <= count + 2'd1;
            end else if (pop && !push) begin
                count <= count - 2'd1;
            end
        end
    end
endmodule // tbf_buf2

/* File: design/tbf_framer.v */
/*
 * Card-side block framer: parses terminal blocks from a received byte
 * stream, checks them, answers supervisory requests, acknowledges info
 * blocks, and builds outgoing blocks through a two-entry buffer.
 * Assumes a character layer on the same clock that delivers whole bytes
 * with a valid strobe only and takes whole bytes with valid/ready; parity and timing are handled there.
 */
`timescale 1ns/1ps
`include "tbf_defs.vh"
module tbf_framer (
    input wire clk, // 100 MHz clock
    input wire rst, // async reset, active high
    input wire rx_valid, // received byte strobe
    input wire [7:0] rx_data, // received byte
    input wire rx_parity_err, // parity error on this byte
    output wire tx_valid, // byte to send
    input wire tx_ready, // character layer takes byte
    output wire [7:0] tx_data, // byte to send
    input wire app_send, // app starts an info block
    input wire app_more, // chained info block
    input wire [7:0] app_len, // info bytes of app block
    input wire app_wtx, // app asks for waiting extension
    input wire [7:0] app_wtx_mult, // extension multiplier byte
    output wire app_data_req, // pulse: next info byte wanted
    input wire [7:0] app_data, // info byte from app
    output reg rx_inf_valid, // pulse: info byte of an I-block, given before its check byte is seen
    output reg [7:0] rx_inf_data, // that byte
    output reg rx_block_done, // pulse: good block received
    output reg rx_block_err, // pulse: bad block received
    output reg [3:0] rx_err_code, // reason of last bad block
    output reg [7:0] ifsd, // terminal receive size
    output reg our_turn, // card holds the right to send
    output reg connected, // logical connection set up
    output reg wtx_granted, // pulse: wait response arrived
    output reg ns_tx, // next send sequence
    output reg nr_rx // expected receive sequence
);
    localparam RX_NAD = 3'd0;
    localparam RX_PCB = 3'd1;
    localparam RX_LEN = 3'd2;
    localparam RX_INF = 3'd3;
    localparam RX_EDC = 3'd4;
    localparam TX_IDLE = 3'd0;
    localparam TX_NAD = 3'd1;
    localparam TX_PCB = 3'd2;
    localparam TX_LEN = 3'd3;
    localparam TX_INF = 3'd4;
    localparam TX_EDC = 3'd5;

    // classifies a control byte and checks its coding
    function pcb_ok;
        input [7:0] pcb;
        input [7:0] len;
        begin
            if (!pcb[`TBF_PCB_I_BIT]) begin
                pcb_ok = (pcb[4:0] == 5'h00);
            end else if (pcb[7:5] == 3'b100) begin
                pcb_ok = (pcb[3:0] <= `TBF_R_OTHER) && (len == 8'h00);
            end else if (pcb[7:6] == 2'b11) begin
                if (pcb[4:0] == `TBF_S_IFS || pcb[4:0] == `TBF_S_WTX) begin
                    pcb_ok = (len == 8'h01);
                end else if (pcb[4:0] <= `TBF_S_VPP) begin
                    pcb_ok = (len == 8'h00);
                end else begin
                    pcb_ok = 1'b0;
                end
            end else begin
                pcb_ok = 1'b0;
            end
        end
    endfunction

    reg [2:0] rx_state;
    reg [7:0] rx_pcb;
    reg [7:0] rx_len;
    reg [7:0] rx_cnt;
    reg [7:0] rx_lrc;
    reg [7:0] rx_inf0;
    reg rx_bad_par;
    reg rx_bad_nad;
    reg first_seen;
    reg [7:0] ifsc;
    // pending reply
    reg [7:0] tx_pcb;
    reg [7:0] tx_len;
    reg [7:0] tx_inf0;
    reg tx_is_app;
    reg tx_go;
    reg [2:0] tx_state;
    reg [7:0] tx_cnt;
    reg [7:0] tx_lrc;
    reg wtx_pending;

    wire [7:0] rx_lrc_next = rx_lrc ^ rx_data;
    wire buf_ready;
    reg buf_valid;
    reg [7:0] buf_byte;

    tbf_buf2 #(.WIDTH(8)) u_txbuf (
        .clk(clk),
        .rst(rst),
        .in_valid(buf_valid),
        .in_ready(buf_ready),
        .in_data(buf_byte),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    assign app_data_req = (tx_state == TX_INF) && tx_is_app && buf_ready;

    always @* begin
        buf_valid = 1'b0;
        buf_byte = 8'h00;
        case (tx_state)
            TX_NAD: begin
                buf_valid = 1'b1;
                buf_byte = `TBF_NAD_DEFAULT;
            end
            TX_PCB: begin
                buf_valid = 1'b1;
                buf_byte = tx_pcb;
            end
            TX_LEN: begin
                buf_valid = 1'b1;
                buf_byte = tx_len;
            end
            TX_INF: begin
                buf_valid = 1'b1;
                buf_byte = tx_is_app ? app_data : tx_inf0;
            end
            TX_EDC: begin
                buf_valid = 1'b1;
                buf_byte = tx_lrc;
            end
            default: begin
                buf_valid = 1'b0;
            end
        endcase
    end

    // receive path
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_state <= RX_NAD;
            rx_pcb <= 8'h00;
            rx_len <= 8'h00;
            rx_cnt <= 8'h00;
            rx_lrc <= 8'h00;
            rx_inf0 <= 8'h00;
            rx_bad_par <= 1'b0;
            rx_bad_nad <= 1'b0;
            first_seen <= 1'b0;
            connected <= 1'b0;
            rx_inf_valid <= 1'b0;
            rx_inf_data <= 8'h00;
            rx_block_done <= 1'b0;
            rx_block_err <= 1'b0;
            rx_err_code <= 4'h0;
            ifsd <= `TBF_IFS_DEFAULT;
            ifsc <= `TBF_IFS_DEFAULT;
            nr_rx <= 1'b0;
            ns_tx <= 1'b0;
            our_turn <= 1'b0;
            tx_go <= 1'b0;
            tx_pcb <= 8'h00;
            tx_len <= 8'h00;
            tx_inf0 <= 8'h00;
            tx_is_app <= 1'b0;
            wtx_granted <= 1'b0;
            wtx_pending <= 1'b0;
        end else begin
            rx_inf_valid <= 1'b0;
            rx_block_done <= 1'b0;
            rx_block_err <= 1'b0;
            wtx_granted <= 1'b0;
            tx_go <= 1'b0;
            if (tx_state == TX_EDC && buf_ready) begin
                our_turn <= 1'b0;
                if (tx_pcb[`TBF_PCB_I_BIT] == 1'b0) begin
                    ns_tx <= ~ns_tx;
                end
                if (tx_pcb[7:6] == 2'b11 && !tx_pcb[`TBF_PCB_S_RSP_BIT]) begin
                    wtx_pending <= 1'b1;
                end
            end
            // application initiated blocks while card holds the turn
            if (our_turn && tx_state == TX_IDLE && !tx_go) begin
                if (app_wtx) begin
                    tx_pcb <= `TBF_PCB_S_BASE | {3'b000, `TBF_S_WTX};
                    tx_len <= 8'h01;
                    tx_inf0 <= app_wtx_mult;
                    tx_is_app <= 1'b0;
                    tx_go <= 1'b1;
                end else if (app_send) begin
                    tx_pcb <= {1'b0, ns_tx, app_more, 5'h00};
                    tx_len <= (app_len > ifsd) ? ifsd : app_len;
                    tx_is_app <= (app_len != 8'h00);
                    tx_go <= 1'b1;
                end
            end
            if (rx_valid && !our_turn) begin
                rx_lrc <= rx_lrc_next;
                if (rx_parity_err) begin
                    rx_bad_par <= 1'b1;
                end
                case (rx_state)
                    RX_NAD: begin
                        rx_lrc <= rx_data;
                        rx_bad_par <= rx_parity_err;
                        // only address pair zero, unused bits zero
                        rx_bad_nad <= (rx_data != `TBF_NAD_DEFAULT);
                        rx_state <= RX_PCB;
                    end
                    RX_PCB: begin
                        rx_pcb <= rx_data;
                        rx_state <= RX_LEN;
                    end
                    RX_LEN: begin
                        rx_len <= rx_data;
                        rx_cnt <= 8'h00;
                        // length 00 skips the information field
                        rx_state <= (rx_data == 8'h00) ? RX_EDC : RX_INF;
                    end
                    RX_INF: begin
                        if (rx_cnt == 8'h00) begin
                            rx_inf0 <= rx_data;
                        end
                        rx_cnt <= rx_cnt + 8'h01;
                        if (rx_cnt + 8'h01 == rx_len) begin
                            rx_state <= RX_EDC;
                        end
                    end
                    default: begin
                        rx_state <= RX_NAD;
                        our_turn <= 1'b1;
                        tx_go <= 1'b1;
                        tx_is_app <= 1'b0;
                        tx_len <= 8'h00;
                        if (rx_bad_par || rx_parity_err || rx_lrc_next != 8'h00) begin
                            rx_block_err <= 1'b1;
                            rx_err_code <= `TBF_R_EDC;
                            tx_pcb <= {3'b100, nr_rx, `TBF_R_EDC};
                        end else if (rx_bad_nad || rx_len == `TBF_LEN_RFU ||
                                     !pcb_ok(rx_pcb, rx_len) ||
                                     (!first_seen && !rx_pcb[`TBF_PCB_I_BIT] &&
                                      rx_pcb[`TBF_PCB_NS_BIT]) ||
                                     (!first_seen && rx_pcb[7:6] == 2'b10) ||
                                     (!rx_pcb[`TBF_PCB_I_BIT] && rx_len > ifsc)) begin
                            // first block must be I(0) or S
                            rx_block_err <= 1'b1;
                            rx_err_code <= `TBF_R_OTHER;
                            tx_pcb <= {3'b100, nr_rx, `TBF_R_OTHER};
                        end else begin
                            rx_block_done <= 1'b1;
                            first_seen <= 1'b1;
                            connected <= 1'b1;
                            if (!rx_pcb[`TBF_PCB_I_BIT]) begin
                                nr_rx <= ~rx_pcb[`TBF_PCB_NS_BIT];
                                if (rx_pcb[`TBF_PCB_M_BIT]) begin
                                    // ack chain with R of the other number
                                    tx_pcb <= {3'b100, ~rx_pcb[`TBF_PCB_NS_BIT],
                                               `TBF_R_OK};
                                end else begin
                                    // app answers with its own I-block
                                    tx_go <= 1'b0;
                                end
                            end else if (rx_pcb[7:5] == 3'b100) begin
                                tx_go <= 1'b0; // app resends or continues
                            end else if (!rx_pcb[`TBF_PCB_S_RSP_BIT]) begin
                                tx_pcb <= rx_pcb | 8'h20;
                                tx_len <= rx_len;
                                tx_inf0 <= rx_inf0;
                                if (rx_pcb[4:0] == `TBF_S_IFS) begin
                                    ifsd <= (rx_inf0 > `TBF_IFSD_MAX || rx_inf0 == 8'h00)
                                            ? `TBF_IFSD_MAX : rx_inf0;
                                end
                                if (rx_pcb[4:0] == `TBF_S_RESYNCH) begin
                                    ns_tx <= 1'b0;
                                    nr_rx <= 1'b0;
                                end
                            end else begin
                                tx_go <= 1'b0;
                                if (wtx_pending && rx_pcb[4:0] == `TBF_S_WTX) begin
                                    wtx_granted <= 1'b1;
                                end
                                wtx_pending <= 1'b0;
                            end
                        end
                    end
                endcase
                if (rx_state == RX_INF) begin
                    rx_inf_valid <= !rx_pcb[`TBF_PCB_I_BIT];
                    rx_inf_data <= rx_data;
                end
            end
        end
    end

    // transmit path; stalls on a full buffer so no byte is lost
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_cnt <= 8'h00;
            tx_lrc <= 8'h00;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_lrc <= 8'h00;
                    tx_cnt <= 8'h00;
                    if (tx_go) begin
                        tx_state <= TX_NAD;
                    end
                end
                TX_NAD, TX_PCB: begin
                    if (buf_ready) begin
                        tx_lrc <= tx_lrc ^ buf_byte;
                        tx_state <= tx_state + 3'd1;
                    end
                end
                TX_LEN: begin
                    if (buf_ready) begin
                        tx_lrc <= tx_lrc ^ buf_byte;
                        tx_state <= (tx_len == 8'h00) ? TX_EDC : TX_INF;
                    end
                end
                TX_INF: begin
                    if (buf_ready) begin
                        tx_lrc <= tx_lrc ^ buf_byte;
                        tx_cnt <= tx_cnt + 8'h01;
                        if (tx_cnt + 8'h01 == tx_len) begin
                            tx_state <= TX_EDC;
                        end
                    end
                end
                default: begin
                    if (buf_ready) begin
                        tx_state <= TX_IDLE;
                    end
                end
            endcase
        end
    end
endmodule // tbf_framer

/* File: sim/tbf_props.sv */
/* checker of the framer's ports: outgoing block shape, pulses, turn.
   assumes it is bound to tbf_framer, one clock, async reset. */
`timescale 1ns/1ps
module tbf_props (
    input wire clk, // clock
    input wire rst, // async reset, active high
    input wire tx_valid, // byte offered
    input wire tx_ready, // byte taken
    input wire [7:0] tx_data, // byte out
    input wire rx_block_done, // good block pulse
    input wire rx_block_err, // bad block pulse
    input wire [3:0] rx_err_code, // bad block reason
    input wire rx_inf_valid, // info byte pulse
    input wire [7:0] ifsd, // terminal size
    input wire our_turn, // right to send
    input wire connected, // connection up
    input wire wtx_granted // wait response pulse
);
    // byte position inside the outgoing block, found from its length byte
    reg [8:0] idx;
    reg [7:0] blen;
    reg [7:0] bpcb;
    reg [7:0] lrc;
    wire hs = tx_valid && tx_ready;
    wire last = idx > 9'd2 && idx == {1'b0, blen} + 9'd3;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            idx <= 9'd0;
            blen <= 8'h00;
            bpcb <= 8'h00;
            lrc <= 8'h00;
        end else if (hs) begin
            idx <= last ? 9'd0 : idx + 9'd1;
            lrc <= last ? 8'h00 : lrc ^ tx_data;
            if (idx == 9'd1) bpcb <= tx_data;
            if (idx == 9'd2) blen <= tx_data;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_nad; hs && idx == 9'd0 |-> tx_data == 8'h00; endproperty
    a_nad: assert property (p_nad) else $error("bad node address");
    property p_pcb;
        hs && idx == 9'd1 |-> !tx_data[7]
            || (tx_data[7:5] == 3'b100 && tx_data[3:0] <= 4'h2)
            || (tx_data[7:6] == 2'b11 && tx_data[4:0] <= 5'h04);
    endproperty
    a_pcb: assert property (p_pcb) else $error("bad control");
    property p_len;
        hs && idx == 9'd2 |-> tx_data <= 8'hfe
            && (bpcb[7:6] != 2'b10 || tx_data == 8'h00)
            && (bpcb[7:6] != 2'b11 || tx_data == {7'h00, bpcb[0]});
    endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_edc; hs && last |-> tx_data == lrc; endproperty
    a_edc: assert property (p_edc) else $error("bad check byte");
    property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_hold: assert property (p_hold) else $error("stalled byte lost");
    property p_turn; rx_block_done || rx_block_err |-> our_turn; endproperty
    a_turn: assert property (p_turn) else $error("turn not taken");
    property p_err;
        rx_block_err |-> !rx_block_done
            && (rx_err_code == 4'h1 || rx_err_code == 4'h2);
    endproperty
    a_err: assert property (p_err) else $error("bad error code");
    property p_inf; rx_inf_valid |-> !our_turn; endproperty
    a_inf: assert property (p_inf) else $error("turn taken early");
    property p_ifsd; ifsd != 8'h00 && ifsd <= 8'hfe; endproperty
    a_ifsd: assert property (p_ifsd) else $error("size out of range");
    property p_dflt; $fell(rst) |-> ifsd == 8'h20; endproperty
    a_dflt: assert property (p_dflt) else $error("size default");
    property p_conn; connected |=> connected; endproperty
    a_conn: assert property (p_conn) else $error("connection lost");
    property p_wtx; wtx_granted |=> !wtx_granted [*2]; endproperty
    a_wtx: assert property (p_wtx) else $error("wait pulse long");
    c_err: cover property (rx_block_err);
    c_wtx: cover property (wtx_granted);
    c_stall: cover property (tx_valid && !tx_ready);
endmodule // tbf_props
bind tbf_framer tbf_props u_props (.clk(clk), .rst(rst),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_block_done(rx_block_done), .rx_block_err(rx_block_err),
    .rx_err_code(rx_err_code), .rx_inf_valid(rx_inf_valid), .ifsd(ifsd),
    .our_turn(our_turn), .connected(connected), .wtx_granted(wtx_granted));

/* File: sim/tbf_term.sv */
/* terminal model: sends whole blocks to the card, collects its bytes.
   assumes the card framer on the same clock. */
`timescale 1ns/1ps
module tbf_term (
    input wire clk, // clock
    input wire slow, // stall the card every other cycle
    input wire tx_valid, // card byte offered
    input wire [7:0] tx_data, // card byte
    output reg tx_ready, // card byte taken
    output reg rx_valid, // byte to the card
    output reg [7:0] rx_data, // byte to the card
    output reg rx_parity_err // parity flag on byte par_k
);
    logic [7:0] got [$];
    int par_k = -1; // byte index that carries a parity flag
    initial begin
        tx_ready = 1'b1;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_parity_err = 1'b0;
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) got.push_back(tx_data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    // info bytes count up from inf0; bad spoils the check byte
    task automatic send_blk(input logic [7:0] nad, pcb, len, inf0,
        input logic bad);
        logic [7:0] b [$];
        logic [7:0] x;
        b = {nad, pcb, len};
        for (int k = 0; k < len; k++) b.push_back(inf0 + 8'(k));
        x = 8'h00;
        foreach (b[k]) x = x ^ b[k];
        b.push_back(bad ? ~x : x);
        foreach (b[k]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= b[k];
            rx_parity_err <= (k == par_k);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_parity_err <= 1'b0;
        // released line must not keep showing the last byte
        rx_data <= ~b[b.size()-1];
    endtask
endmodule // tbf_term

/* File: sim/tb_top.sv */
/* self-checking bench of the block framer.
   assumes the terminal model and the bound checker. */
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic [7:0] nad, pcb, len, inf0; logic bad;
        logic [7:0] rpcb, rlen, rinf;} tbf_row_t;
    logic clk, rst, slow, app_send, app_more, app_wtx, wtx_seen;
    logic [7:0] app_len, app_wtx_mult, app_data;
    logic [7:0] inf_q [$];
    wire tx_valid, tx_ready, rx_valid, rx_parity_err, app_data_req;
    wire rx_inf_valid, rx_block_done, rx_block_err, our_turn, connected;
    wire wtx_granted, ns_tx, nr_rx;
    wire [7:0] tx_data, rx_data, rx_inf_data, ifsd;
    wire [3:0] rx_err_code;
    int n_fail = 0;
    int cmp_count = 0;
    tbf_row_t rows [7] = '{
        '{8'h00, 8'hc0, 8'h00, 8'h00, 1'b0, 8'he0, 8'h00, 8'h00},
        '{8'h00, 8'hc1, 8'h01, 8'h40, 1'b0, 8'he1, 8'h01, 8'h40},
        '{8'h00, 8'h20, 8'h02, 8'h11, 1'b0, 8'h90, 8'h00, 8'h00},
        '{8'h00, 8'h40, 8'h02, 8'h11, 1'b1, 8'h91, 8'h00, 8'h00},
        '{8'h88, 8'h40, 8'h00, 8'h00, 1'b0, 8'h92, 8'h00, 8'h00},
        '{8'h00, 8'h40, 8'h21, 8'h01, 1'b0, 8'h92, 8'h00, 8'h00},
        '{8'h00, 8'hc2, 8'h00, 8'h00, 1'b0, 8'he2, 8'h00, 8'h00}};
    tbf_framer dut (.clk(clk), .rst(rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_parity_err(rx_parity_err),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
        .app_send(app_send), .app_more(app_more), .app_len(app_len),
        .app_wtx(app_wtx), .app_wtx_mult(app_wtx_mult),
        .app_data_req(app_data_req), .app_data(app_data),
        .rx_inf_valid(rx_inf_valid), .rx_inf_data(rx_inf_data),
        .rx_block_done(rx_block_done), .rx_block_err(rx_block_err),
        .rx_err_code(rx_err_code), .ifsd(ifsd), .our_turn(our_turn),
        .connected(connected), .wtx_granted(wtx_granted), .ns_tx(ns_tx),
        .nr_rx(nr_rx));
    tbf_term u_term (.clk(clk), .slow(slow), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_parity_err(rx_parity_err));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (app_data_req) app_data <= app_data + 8'h01;
        if (rx_inf_valid) inf_q.push_back(rx_inf_data);
        if (wtx_granted) wtx_seen <= 1'b1;
    end
    task automatic check(input string what, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // waits for a whole card block and compares it byte by byte
    task automatic expect_blk(input logic [7:0] pcb, len, inf0);
        logic [7:0] e [$];
        logic [7:0] x;
        int t;
        e = {8'h00, pcb, len};
        for (int k = 0; k < len; k++) e.push_back(inf0 + 8'(k));
        x = 8'h00;
        foreach (e[k]) x = x ^ e[k];
        e.push_back(x);
        t = 0;
        while (u_term.got.size() < e.size() && t < 400) begin
            @(posedge clk);
            t++;
        end
        foreach (e[k]) check("tx byte",
            u_term.got.size() > 0 ? u_term.got.pop_front() : 8'hxx, e[k]);
    endtask
    initial begin
        #200us;
        n_fail++;
        give_verdict();
    end
    initial begin
        rst = 1'b1;
        slow = 1'b0;
        {app_send, app_more, app_wtx, wtx_seen} = 4'h0;
        {app_len, app_wtx_mult, app_data} = {8'h00, 8'h00, 8'h31};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("ifsd", ifsd, 8'h20);
        check("seq", {6'h00, ns_tx, nr_rx}, 8'h00);
        check("turn", {6'h00, our_turn, connected}, 8'h00);
        foreach (rows[i]) begin
            u_term.send_blk(rows[i].nad, rows[i].pcb,
                rows[i].len, rows[i].inf0, rows[i].bad);
            expect_blk(rows[i].rpcb, rows[i].rlen,
                rows[i].rinf);
        end
        #1;
        check("connected", {7'h00, connected}, 8'h01);
        check("ifsd new", ifsd, 8'h40);
        inf_q.delete();
        u_term.send_blk(8'h00, 8'h40, 8'h03, 8'h51, 1'b0);
        repeat (3) @(posedge clk);
        #1;
        check("no auto reply", 8'(u_term.got.size()), 8'h00);
        check("turn", {7'h00, our_turn}, 8'h01);
        check("nr", {7'h00, nr_rx}, 8'h00);
        check("inf count", 8'(inf_q.size()), 8'h03);
        foreach (inf_q[k]) check("inf", inf_q[k], 8'h51 + 8'(k));
        @(posedge clk);
        app_wtx_mult <= 8'h05;
        app_wtx <= 1'b1;
        for (int t = 0; t < 50 && !tx_valid; t++) @(posedge clk);
        app_wtx <= 1'b0;
        expect_blk(8'hc3, 8'h01, 8'h05);
        u_term.send_blk(8'h00, 8'he3, 8'h01, 8'h05, 1'b0);
        for (int t = 0; t < 20 && !wtx_seen; t++) @(posedge clk);
        check("wait granted", {7'h00, wtx_seen}, 8'h01);
        slow <= 1'b1;
        app_len <= 8'h02;
        app_data <= 8'h31;
        app_send <= 1'b1;
        for (int t = 0; t < 50 && !tx_valid; t++) @(posedge clk);
        app_send <= 1'b0;
        expect_blk(8'h00, 8'h02, 8'h31);
        slow <= 1'b0;
        #1;
        check("ns", {7'h00, ns_tx}, 8'h01);
        @(posedge clk);
        app_send <= 1'b1;
        repeat (6) @(posedge clk);
        app_send <= 1'b0;
        #1;
        check("refused", 8'(u_term.got.size()), 8'h00);
        u_term.par_k = 1;
        u_term.send_blk(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        expect_blk(8'h81, 8'h00, 8'h00);
        check("err code", {4'h0, rx_err_code}, 8'h01);
        give_verdict();
    end
endmodule // tb_top
